// >>> common/csm_pkg.sv
// Purpose: constants and types of the camera special mode sequencer
// Assumes: 100 MHz system clock, AXI4-Lite register access
// Notes: temperatures are signed whole degrees Celsius, 10 bits
package csm_pkg;
  // register byte offsets
  localparam logic [7:0] CSM_REG_CMD = 8'h00;
  localparam logic [7:0] CSM_REG_STATUS = 8'h04;
  localparam logic [7:0] CSM_REG_TRIM = 8'h08;
  localparam logic [7:0] CSM_REG_DIAG_SP = 8'h0C;
  localparam logic [7:0] CSM_REG_OUTPUTS = 8'h10;
  localparam logic [7:0] CSM_REG_PERIGEE = 8'h14;
  localparam logic [7:0] CSM_REG_IDLE_CFG = 8'h18;
  // command register fields
  localparam int CSM_CMD_CODE_LSB = 0;
  localparam int CSM_CMD_CCD_LSB = 4;
  localparam int CSM_CMD_TIMING_BIT = 8;
  localparam int CSM_CMD_PARTIAL_BIT = 9;
  localparam int CSM_CMD_SIM_BIT = 10;
  localparam int CSM_CMD_PATTERN_BIT = 11;
  localparam int CSM_CMD_UNIT_LSB = 12;
  // telecommand codes
  localparam logic [3:0] CSM_TC_IDLE = 4'h1;
  localparam logic [3:0] CSM_TC_SAFE = 4'h2;
  localparam logic [3:0] CSM_TC_DIAG = 4'h3;
  localparam logic [3:0] CSM_TC_ANNEAL = 4'h4;
  localparam logic [3:0] CSM_TC_DEICE = 4'h5;
  localparam logic [3:0] CSM_TC_DECONT = 4'h6;
  localparam logic [3:0] CSM_TC_TEST = 4'h7;
  // heater / actuator vector bit positions
  localparam int CSM_HB_CCD = 0;
  localparam int CSM_HB_ANNEAL = 1;
  localparam int CSM_HB_SHROUD = 2;
  localparam int CSM_HB_DOOR_HTR = 3;
  localparam int CSM_HB_CCD_PWR = 4;
  localparam int CSM_HB_CAL = 5;
  localparam int CSM_HB_DOOR_OPEN = 6;
  localparam int CSM_HB_W = 7;
  // setpoints: +130, -70, -20, and -130 after reset
  localparam logic signed [9:0] CSM_SP_ANNEAL = 10'sh082;
  localparam logic signed [9:0] CSM_SP_DEICE = 10'sh3BA;
  localparam logic signed [9:0] CSM_SP_DECONT = 10'sh3EC;
  localparam logic signed [9:0] CSM_SP_RST = 10'sh37E;
  localparam logic [CSM_HB_W-1:0] CSM_HEAT_RST = 7'h01;
  localparam logic [1:0] CSM_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSM_RESP_SLVERR = 2'h2;
  // timing
  localparam int CSM_CLK_HZ = 100_000_000;
  localparam int CSM_BUS_RATE_HZ = 1_000_000;
  localparam int CSM_BUS_DIV = CSM_CLK_HZ / CSM_BUS_RATE_HZ;
  localparam int CSM_HK_PERIOD_MS = 1000;
  localparam int CSM_HK_PERIOD_CYC = CSM_HK_PERIOD_MS * (CSM_CLK_HZ / 1000);

  typedef enum logic [6:0] {
    CSM_M_IDLE = 7'h01,
    CSM_M_SAFE = 7'h02,
    CSM_M_DIAG = 7'h04,
    CSM_M_ANNEAL = 7'h08,
    CSM_M_DEICE = 7'h10,
    CSM_M_DECONT = 7'h20,
    CSM_M_TEST = 7'h40
  } csm_mode_t;

  typedef enum logic [2:0] {
    CSM_P_CAPTURE = 3'h1,
    CSM_P_SEND = 3'h2,
    CSM_P_HK = 3'h4
  } csm_phase_t;
endpackage

// >>> verilog/csm_sequencer.sv
// Purpose: special mode sequencer with AXI4-Lite telecommand registers
// Assumes: pixel, housekeeping and tx ports synchronous to i_clock
// Notes: diagnostic frame buffer is flip-flops, DEPTH words
// Function
// - special modes entered only from idle by command
// - special modes accept only idle or safe commands; diagnostics also accepts diag as a restart
// - diagnostics reads one selected ccd, chosen options
// - one frame stored, other ccds discarded
// - stored pixels and housekeeping sent at bus rate
// - after sending the housekeeping word, restart if pending, else return to idle
// - diagnostics auto-returns idle unless restart pending
// - idle command aborts diagnostics immediately
// - diagnostics: shroud, anneal, door heaters off
// - anneal/deice entry opens filter wheel if needed
// - anneal: ccds off, setpoint 130 plus trim
// - anneal: anneal and shroud heaters only
// - extra-heating: wheel closed during perigee if flagged
// - deice: ccds off, -70, ccd+shroud heaters
// - deice/decont: shroud temperature in housekeeping
// - decont: ccds off, wheel/door open, -20
// - decont: periodic housekeeping requests
// - simulated source replaces ccd data in test
// - unit tests triggerable, may suspend housekeeping
// - test injects stored patterns at chain start
// - test: cal source, shroud, anneal, door off
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module csm_sequencer import csm_pkg::*; #(
  parameter int DEPTH = 64,
  parameter int HK_PERIOD_CYC = CSM_HK_PERIOD_CYC,
  parameter int BUS_DIV = CSM_BUS_DIV
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [31:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [31:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_pix_valid,
  input wire logic [3:0] i_pix_ccd,
  input wire logic [15:0] i_pix_energy,
  input wire logic i_pix_frame_end,
  output logic o_ro_capture,
  output logic [3:0] o_ro_ccd_sel,
  output logic o_ro_timing,
  output logic o_ro_partial,
  output logic o_tx_valid,
  output logic [15:0] o_tx_data,
  output logic o_tx_hk,
  input wire logic i_tx_ready,
  input wire logic [15:0] i_hk_word,
  input wire logic i_fw_is_open,
  input wire logic i_unit_test_busy,
  output logic o_fw_open_cmd,
  output logic o_fw_close_cmd,
  output logic o_hk_req,
  output logic o_hk_shroud_incl,
  output logic [6:0] o_mode,
  output logic o_ccd_heater_en,
  output logic o_anneal_heater_en,
  output logic o_shroud_heater_en,
  output logic o_door_opening_heaters_en,
  output logic o_ccd_power_en,
  output logic o_cal_source_en,
  output logic o_door_open_cmd,
  output logic [9:0] o_setpoint,
  output logic o_sim_source_en,
  output logic o_pattern_inject_en,
  output logic o_unit_test_start,
  output logic [3:0] o_unit_test_sel
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  if (DEPTH < 2 || DEPTH > 4096 || (1 << AW) != DEPTH) begin : g_chk_depth
    $error("DEPTH must be a power of two from 2 to 4096");
  end
  if (BUS_DIV < 1 || BUS_DIV > 65535 || HK_PERIOD_CYC < 2) begin : g_chk_time
    $error("BUS_DIV or HK_PERIOD_CYC out of range");
  end

  typedef struct packed {
    csm_mode_t mode;
    csm_phase_t phase;
    logic [DEPTH-1:0][15:0] ram;
    logic [CW-1:0] wr_cnt;
    logic [CW-1:0] rd_idx;
    logic [3:0] ccd_sel;
    logic timing;
    logic partial;
    logic restart;
    logic [3:0] rs_ccd;
    logic rs_timing;
    logic rs_partial;
    logic tx_valid;
    logic [15:0] tx_data;
    logic tx_hk;
    logic rejected;
    logic [7:0] trim;
    logic [9:0] diag_sp;
    logic perigee;
    logic [1:0] idle_cfg;
    logic fw_open;
    logic fw_close;
    logic fw_parked;
    logic sim_src;
    logic pattern;
    logic [3:0] unit_sel;
    logic unit_start;
    logic [CSM_HB_W-1:0] heat;
    logic [9:0] setpoint;
    logic [31:0] hk_cnt;
    logic hk_req;
    logic [15:0] bus_cnt;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } csm_state_t;

  csm_state_t q;
  csm_state_t next_q;

  // actuator pattern per mode; idle follows both idle configuration bits, diag only the cal bit, test only the ccd power bit
  function automatic logic [CSM_HB_W-1:0] heat_of(input csm_mode_t m, input logic [1:0] cfg);
    logic [CSM_HB_W-1:0] h;
    h = '0;
    unique case (m)
      CSM_M_IDLE: begin
        h[CSM_HB_CCD] = 1'b1;
        h[CSM_HB_CCD_PWR] = cfg[0];
        h[CSM_HB_CAL] = cfg[1];
      end
      CSM_M_SAFE: h[CSM_HB_CCD] = 1'b1;
      CSM_M_DIAG: begin
        h[CSM_HB_CCD] = 1'b1;
        h[CSM_HB_CCD_PWR] = 1'b1;
        h[CSM_HB_CAL] = cfg[1];
      end
      CSM_M_ANNEAL: begin
        h[CSM_HB_ANNEAL] = 1'b1;
        h[CSM_HB_SHROUD] = 1'b1;
        h[CSM_HB_DOOR_OPEN] = 1'b1;
      end
      CSM_M_DEICE: begin
        h[CSM_HB_CCD] = 1'b1;
        h[CSM_HB_SHROUD] = 1'b1;
        h[CSM_HB_DOOR_OPEN] = 1'b1;
      end
      CSM_M_DECONT: begin
        h[CSM_HB_ANNEAL] = 1'b1;
        h[CSM_HB_SHROUD] = 1'b1;
        h[CSM_HB_DOOR_OPEN] = 1'b1;
      end
      CSM_M_TEST: begin
        h[CSM_HB_CCD] = 1'b1;
        h[CSM_HB_CCD_PWR] = cfg[0];
      end
      default: h = CSM_HEAT_RST;
    endcase
    return h;
  endfunction

  function automatic logic is_extra(input csm_mode_t m);
    return (m == CSM_M_ANNEAL) || (m == CSM_M_DEICE) || (m == CSM_M_DECONT);
  endfunction

  always_comb begin
    logic bus_en;
    logic [31:0] wmask;
    logic [31:0] wd;
    logic cmd_stb;
    logic [3:0] code;
    logic [9:0] trim_x;
    bus_en = 1'b0;
    wmask = '0;
    wd = '0;
    cmd_stb = 1'b0;
    code = '0;
    trim_x = '0;
    next_q = q;
    next_q.fw_open = 1'b0;
    next_q.fw_close = 1'b0;
    next_q.hk_req = 1'b0;
    next_q.unit_start = 1'b0;

    // bus-rate enable and housekeeping period
    bus_en = (q.bus_cnt == 16'(BUS_DIV - 1));
    next_q.bus_cnt = bus_en ? '0 : q.bus_cnt + 16'h0001;
    if (q.hk_cnt == 32'(HK_PERIOD_CYC - 1)) begin
      next_q.hk_cnt = '0;
      // a running unit test may starve housekeeping
      next_q.hk_req = (q.mode != CSM_M_SAFE) && (q.mode != CSM_M_DIAG) && !i_unit_test_busy;
    end else begin
      next_q.hk_cnt = q.hk_cnt + 32'h0000_0001;
    end

    // axi write side: address and data in either order
    if (!q.aw_got && !q.bvalid && i_s_axi_awvalid) begin
      next_q.aw_got = 1'b1;
      next_q.aw_addr = i_s_axi_awaddr[7:0];
    end
    if (!q.w_got && !q.bvalid && i_s_axi_wvalid) begin
      next_q.w_got = 1'b1;
      next_q.w_data = i_s_axi_wdata;
      next_q.w_strb = i_s_axi_wstrb;
    end
    if (q.bvalid && i_s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = CSM_RESP_OKAY;
      wmask = {{8{q.w_strb[3]}}, {8{q.w_strb[2]}}, {8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
      wd = q.w_data & wmask;
      unique case ({q.aw_addr[7:2], 2'b00})
        CSM_REG_CMD: cmd_stb = 1'b1;
        CSM_REG_TRIM: next_q.trim = (q.trim & ~wmask[7:0]) | wd[7:0];
        CSM_REG_DIAG_SP: next_q.diag_sp = (q.diag_sp & ~wmask[9:0]) | wd[9:0];
        CSM_REG_PERIGEE: next_q.perigee = q.w_strb[0] ? wd[0] : q.perigee;
        CSM_REG_IDLE_CFG: next_q.idle_cfg = (q.idle_cfg & ~wmask[1:0]) | wd[1:0];
        CSM_REG_STATUS, CSM_REG_OUTPUTS: next_q.bresp = CSM_RESP_OKAY;
        default: next_q.bresp = CSM_RESP_SLVERR;
      endcase
    end

    // axi read side
    if (q.rvalid && i_s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (!q.rvalid && i_s_axi_arvalid) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = CSM_RESP_OKAY;
      next_q.rdata = '0;
      unique case ({i_s_axi_araddr[7:2], 2'b00})
        CSM_REG_CMD: next_q.rdata[15:4] = {q.unit_sel, q.pattern, q.sim_src, q.partial, q.timing, q.ccd_sel};
        CSM_REG_STATUS: next_q.rdata = {16'(q.wr_cnt), 1'b0, q.tx_valid, q.restart, q.rejected,
                                        1'b0, q.phase, 1'b0, q.mode};
        CSM_REG_TRIM: next_q.rdata[7:0] = q.trim;
        CSM_REG_DIAG_SP: next_q.rdata[9:0] = q.diag_sp;
        CSM_REG_OUTPUTS: next_q.rdata[22:0] = {q.pattern, q.sim_src, q.fw_parked, 2'b00, q.setpoint, 1'b0, q.heat};
        CSM_REG_PERIGEE: next_q.rdata[0] = q.perigee;
        CSM_REG_IDLE_CFG: next_q.rdata[1:0] = q.idle_cfg;
        default: next_q.rresp = CSM_RESP_SLVERR;
      endcase
    end

    // diagnostic capture and transmit engine
    if (q.mode == CSM_M_DIAG) begin
      unique case (q.phase)
        CSM_P_CAPTURE: begin
          // only the selected ccd lands in the buffer
          if (i_pix_valid && i_pix_ccd == q.ccd_sel && q.wr_cnt < CW'(DEPTH)) begin
            next_q.ram[q.wr_cnt[AW-1:0]] = i_pix_energy;
            next_q.wr_cnt = q.wr_cnt + CW'(1);
          end
          if (i_pix_valid && i_pix_frame_end) begin
            next_q.phase = CSM_P_SEND; // one frame only
            next_q.rd_idx = '0;
          end
        end
        CSM_P_SEND: begin
          if (q.tx_valid && i_tx_ready) begin
            next_q.tx_valid = 1'b0;
            next_q.rd_idx = q.rd_idx + CW'(1);
          end else if (!q.tx_valid && bus_en) begin
            next_q.tx_valid = 1'b1; // unprocessed words at bus rate
            if (q.rd_idx < q.wr_cnt) begin
              next_q.tx_data = q.ram[q.rd_idx[AW-1:0]];
            end else begin
              next_q.tx_data = i_hk_word;
              next_q.tx_hk = 1'b1;
              next_q.phase = CSM_P_HK;
            end
          end
        end
        CSM_P_HK: begin
          if (q.tx_valid && i_tx_ready) begin
            next_q.tx_valid = 1'b0;
            next_q.tx_hk = 1'b0;
            if (q.restart) begin
              next_q.restart = 1'b0;
              next_q.phase = CSM_P_CAPTURE;
              next_q.wr_cnt = '0;
              next_q.ccd_sel = q.rs_ccd;
              next_q.timing = q.rs_timing;
              next_q.partial = q.rs_partial;
            end else begin
              next_q.mode = CSM_M_IDLE;
            end
          end
        end
        default: next_q.phase = CSM_P_CAPTURE;
      endcase
    end

    // telecommand filter
    if (cmd_stb) begin
      code = wd[CSM_CMD_CODE_LSB +: 4];
      next_q.rejected = 1'b0;
      if (q.mode == CSM_M_IDLE && code >= CSM_TC_SAFE && code <= CSM_TC_TEST) begin
        next_q.mode = csm_mode_t'(7'h01 << (code - 4'h1));
        next_q.phase = CSM_P_CAPTURE;
        next_q.wr_cnt = '0;
        next_q.tx_valid = 1'b0;
        next_q.tx_hk = 1'b0;
        next_q.restart = 1'b0;
        next_q.ccd_sel = wd[CSM_CMD_CCD_LSB +: 4];
        next_q.timing = wd[CSM_CMD_TIMING_BIT];
        next_q.partial = wd[CSM_CMD_PARTIAL_BIT];
        next_q.sim_src = (code == CSM_TC_TEST) && wd[CSM_CMD_SIM_BIT];
        next_q.pattern = (code == CSM_TC_TEST) && wd[CSM_CMD_PATTERN_BIT];
        next_q.unit_sel = wd[CSM_CMD_UNIT_LSB +: 4];
        next_q.unit_start = (code == CSM_TC_TEST) && (wd[CSM_CMD_UNIT_LSB +: 4] != 4'h0);
      end else if (q.mode != CSM_M_IDLE && code == CSM_TC_IDLE) begin
        next_q.mode = CSM_M_IDLE; // abort at once
        next_q.tx_valid = 1'b0;
        next_q.tx_hk = 1'b0;
        next_q.restart = 1'b0;
      end else if (q.mode != CSM_M_IDLE && q.mode != CSM_M_SAFE && code == CSM_TC_SAFE) begin
        next_q.mode = CSM_M_SAFE; // emergency exit
        next_q.tx_valid = 1'b0;
        next_q.tx_hk = 1'b0;
        next_q.restart = 1'b0;
      end else if (q.mode == CSM_M_DIAG && code == CSM_TC_DIAG) begin
        next_q.restart = 1'b1;
        next_q.rs_ccd = wd[CSM_CMD_CCD_LSB +: 4];
        next_q.rs_timing = wd[CSM_CMD_TIMING_BIT];
        next_q.rs_partial = wd[CSM_CMD_PARTIAL_BIT];
      end else if (!(q.mode == CSM_M_IDLE && code == CSM_TC_IDLE)) begin
        next_q.rejected = 1'b1; // mode and heaters untouched
      end
    end
    if (next_q.mode != CSM_M_TEST) begin
      next_q.sim_src = 1'b0;
      next_q.pattern = 1'b0;
    end

    // filter wheel: open on entry, park closed over perigee
    if (is_extra(next_q.mode) && !is_extra(q.mode)) begin
      if (next_q.perigee) begin
        next_q.fw_close = 1'b1;
        next_q.fw_parked = 1'b1;
      end else begin
        next_q.fw_open = !i_fw_is_open;
      end
    end else if (is_extra(next_q.mode)) begin
      if (next_q.perigee && !q.fw_parked) begin
        next_q.fw_close = 1'b1;
        next_q.fw_parked = 1'b1;
      end else if (!next_q.perigee && q.fw_parked) begin
        next_q.fw_open = 1'b1;
        next_q.fw_parked = 1'b0;
      end
    end else begin
      next_q.fw_parked = 1'b0;
    end

    // actuators and setpoint follow the mode that will hold next
    next_q.heat = heat_of(next_q.mode, next_q.idle_cfg);
    trim_x = {{2{next_q.trim[7]}}, next_q.trim};
    unique case (next_q.mode)
      CSM_M_ANNEAL: next_q.setpoint = CSM_SP_ANNEAL + trim_x;
      CSM_M_DEICE: next_q.setpoint = CSM_SP_DEICE + trim_x;
      CSM_M_DECONT: next_q.setpoint = CSM_SP_DECONT + trim_x;
      CSM_M_DIAG: next_q.setpoint = next_q.diag_sp;
      default: next_q.setpoint = q.setpoint; // idle keeps the last setpoint
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      q <= '0;
      q.mode <= CSM_M_IDLE;
      q.phase <= CSM_P_CAPTURE;
      q.diag_sp <= CSM_SP_RST;
      q.setpoint <= CSM_SP_RST;
      q.heat <= CSM_HEAT_RST;
    end else begin
      q <= next_q;
    end
  end

  assign o_s_axi_awready = !q.aw_got && !q.bvalid;
  assign o_s_axi_wready = !q.w_got && !q.bvalid;
  assign o_s_axi_bvalid = q.bvalid;
  assign o_s_axi_bresp = q.bresp;
  assign o_s_axi_arready = !q.rvalid;
  assign o_s_axi_rvalid = q.rvalid;
  assign o_s_axi_rdata = q.rdata;
  assign o_s_axi_rresp = q.rresp;
  assign o_ro_capture = (q.mode == CSM_M_DIAG) && (q.phase == CSM_P_CAPTURE);
  assign o_ro_ccd_sel = q.ccd_sel;
  assign o_ro_timing = q.timing;
  assign o_ro_partial = q.partial;
  assign o_tx_valid = q.tx_valid;
  assign o_tx_data = q.tx_data;
  assign o_tx_hk = q.tx_hk;
  assign o_fw_open_cmd = q.fw_open;
  assign o_fw_close_cmd = q.fw_close;
  assign o_hk_req = q.hk_req;
  assign o_hk_shroud_incl = (q.mode == CSM_M_DEICE) || (q.mode == CSM_M_DECONT);
  assign o_mode = q.mode;
  assign o_ccd_heater_en = q.heat[CSM_HB_CCD];
  assign o_anneal_heater_en = q.heat[CSM_HB_ANNEAL];
  assign o_shroud_heater_en = q.heat[CSM_HB_SHROUD];
  assign o_door_opening_heaters_en = q.heat[CSM_HB_DOOR_HTR];
  assign o_ccd_power_en = q.heat[CSM_HB_CCD_PWR];
  assign o_cal_source_en = q.heat[CSM_HB_CAL];
  assign o_door_open_cmd = q.heat[CSM_HB_DOOR_OPEN];
  assign o_setpoint = q.setpoint;
  assign o_sim_source_en = q.sim_src;
  assign o_pattern_inject_en = q.pattern;
  assign o_unit_test_start = q.unit_start;
  assign o_unit_test_sel = q.unit_sel;
endmodule
`default_nettype wire

// >>> sim/csm_sva.sv
// Purpose: mode output checks for the special mode sequencer
// Assumes: bound into csm_sequencer, one clock domain
// Notes: heater sets per mode, entry only from idle
`timescale 1ns/1ps
`default_nettype none
module csm_sva import csm_pkg::*; (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_fw_is_open,
  input wire logic [6:0] o_mode,
  input wire logic o_ccd_heater_en,
  input wire logic o_anneal_heater_en,
  input wire logic o_shroud_heater_en,
  input wire logic o_door_opening_heaters_en,
  input wire logic o_ccd_power_en,
  input wire logic o_cal_source_en,
  input wire logic o_door_open_cmd,
  input wire logic o_hk_shroud_incl,
  input wire logic o_fw_open_cmd,
  input wire logic o_fw_close_cmd
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic [3:0] heat;
  assign heat = {o_ccd_heater_en, o_anneal_heater_en, o_shroud_heater_en, o_door_opening_heaters_en};
  a_diag_heat_off: assert property (o_mode == CSM_M_DIAG |-> heat[2:0] == 3'h0)
    else $error("diag heaters on");
  a_anneal_heat: assert property (o_mode == CSM_M_ANNEAL |-> heat == 4'h6 && !o_ccd_power_en)
    else $error("anneal heater set wrong");
  a_deice_heat: assert property (o_mode == CSM_M_DEICE |-> heat == 4'hA && !o_ccd_power_en)
    else $error("deice heater set wrong");
  a_decont_heat: assert property (o_mode == CSM_M_DECONT |-> heat == 4'h6 && !o_ccd_power_en && o_door_open_cmd)
    else $error("decont heater set wrong");
  a_test_heat_off: assert property (o_mode == CSM_M_TEST |-> heat[2:0] == 3'h0 && !o_cal_source_en)
    else $error("test heaters on");
  a_entry_from_idle: assert property ($changed(o_mode) && !(o_mode inside {CSM_M_IDLE, CSM_M_SAFE})
    |-> $past(o_mode) == CSM_M_IDLE)
    else $error("special mode not entered from idle");
  a_shroud_in_hk: assert property (o_hk_shroud_incl == (o_mode inside {CSM_M_DEICE, CSM_M_DECONT}))
    else $error("shroud housekeeping flag wrong");
  a_wheel_on_entry: assert property ($rose(o_mode[3] | o_mode[4]) && !$past(i_fw_is_open)
    |-> o_fw_open_cmd || o_fw_close_cmd)
    else $error("no wheel command on entry");
  a_one_mode: assert property ($onehot(o_mode))
    else $error("mode not one-hot");
  cover property (o_mode == CSM_M_DIAG ##1 o_mode == CSM_M_IDLE);
  cover property (o_mode == CSM_M_TEST ##1 o_mode == CSM_M_SAFE);
  cover property ($rose(o_fw_close_cmd));
endmodule
bind csm_sequencer csm_sva u_sva (.i_clock, .i_rst, .i_fw_is_open, .o_mode, .o_ccd_heater_en, .o_anneal_heater_en,
  .o_shroud_heater_en, .o_door_opening_heaters_en, .o_ccd_power_en, .o_cal_source_en, .o_door_open_cmd,
  .o_hk_shroud_incl, .o_fw_open_cmd, .o_fw_close_cmd);
`default_nettype wire

// >>> sim/csm_dhb_model.sv
// Purpose: data bus controller taking diagnostic words
// Assumes: one word per ready edge
// Notes: slow mode stalls three cycles in four
`timescale 1ns/1ps
`default_nettype none
module csm_dhb_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic i_valid,
  output logic o_ready
);
  logic [1:0] cnt;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cnt <= 2'h0;
      o_ready <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      o_ready <= i_valid && (!i_slow || cnt == 2'h3);
    end
  end
endmodule
`default_nettype wire

// >>> sim/csm_sequencer_tb_top.sv
// Purpose: self-checking bench for the special mode sequencer
// Assumes: shortened counts, wheel reported closed
// Notes: tx words and reads checked in order
`timescale 1ns/1ps
`default_nettype none
module csm_sequencer_tb_top import csm_pkg::*; ;
  logic i_clock, i_rst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
  logic [31:0] i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_araddr, o_s_axi_rdata;
  logic [3:0] i_s_axi_wstrb, i_pix_ccd, o_ro_ccd_sel;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, slow;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic i_pix_valid, i_pix_frame_end, o_ro_timing, o_tx_valid, o_tx_hk, i_tx_ready, i_fw_is_open, i_unit_test_busy;
  logic [15:0] i_pix_energy, o_tx_data, i_hk_word, seed;
  logic o_fw_open_cmd, o_fw_close_cmd, o_hk_req, o_sim_source_en, o_pattern_inject_en;
  logic [6:0] o_mode;
  logic [9:0] o_setpoint;
  int err_total = 0, tests_run = 0, n_open = 0, n_close = 0, n_hk = 0, n0;
  logic [33:0] rq[$];
  logic [16:0] tq[$];
  logic [31:0] cmds[4] = '{32'h0000_0004, 32'h0000_0005, 32'h0000_0006, 32'h0000_1C07};
  csm_mode_t mds[4] = '{CSM_M_ANNEAL, CSM_M_DEICE, CSM_M_DECONT, CSM_M_TEST};
  logic [9:0] sps[3] = '{CSM_SP_ANNEAL, CSM_SP_DEICE, CSM_SP_DECONT};
  // short counts, quick run
  csm_sequencer #(.DEPTH(8), .HK_PERIOD_CYC(50), .BUS_DIV(4)) dut (.i_clock, .i_rst, .i_s_axi_awaddr,
    .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
    .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
    .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_pix_valid, .i_pix_ccd, .i_pix_energy,
    .i_pix_frame_end, .o_ro_capture(), .o_ro_ccd_sel, .o_ro_timing, .o_ro_partial(), .o_tx_valid, .o_tx_data,
    .o_tx_hk, .i_tx_ready, .i_hk_word, .i_fw_is_open, .i_unit_test_busy, .o_fw_open_cmd, .o_fw_close_cmd,
    .o_hk_req, .o_hk_shroud_incl(), .o_mode, .o_ccd_heater_en(), .o_anneal_heater_en(), .o_shroud_heater_en(),
    .o_door_opening_heaters_en(), .o_ccd_power_en(), .o_cal_source_en(), .o_door_open_cmd(), .o_setpoint,
    .o_sim_source_en, .o_pattern_inject_en, .o_unit_test_start(), .o_unit_test_sel());
  csm_dhb_model u_dhb (.i_clock, .i_rst, .i_slow(slow), .i_valid(o_tx_valid), .o_ready(i_tx_ready));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic ta, tw, tb;
    i_s_axi_awaddr <= {24'h00_0000, a};
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge i_clock);
      ta = i_s_axi_awvalid && o_s_axi_awready;
      tw = i_s_axi_wvalid && o_s_axi_wready;
      tb = o_s_axi_bvalid;
      if (tb) chk(o_s_axi_bresp, resp);
      @(posedge i_clock);
      if (ta) i_s_axi_awvalid <= 1'b0;
      if (tw) i_s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    logic t;
    rq.push_back(exp);
    i_s_axi_araddr <= {24'h00_0000, a};
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(negedge i_clock);
      t = o_s_axi_arready;
      @(posedge i_clock);
    end while (!t);
    i_s_axi_arvalid <= 1'b0;
    do begin
      @(negedge i_clock);
      t = o_s_axi_rvalid;
      @(posedge i_clock);
    end while (!t);
    i_s_axi_rready <= 1'b0;
  endtask
  task automatic diag(input logic s);
    slow <= s;
    wr(CSM_REG_CMD, 32'h0000_0123, CSM_RESP_OKAY);
    chk(o_mode, CSM_M_DIAG);
    chk({o_ro_ccd_sel, o_ro_timing}, 5'h05);
    chk(o_setpoint, 10'h3CE);
    for (int i = 0; i < 20; i++) begin
      seed = lfsr(seed);
      if (!i[0] && i < 16) tq.push_back({1'b0, seed});
      i_pix_valid <= 1'b1;
      i_pix_ccd <= i[0] ? 4'h5 : 4'h2;
      i_pix_energy <= seed;
      i_pix_frame_end <= i == 19;
      @(posedge i_clock);
    end
    i_pix_valid <= 1'b0;
    tq.push_back({1'b1, i_hk_word});
  endtask
  always @(negedge i_clock) begin
    if (o_fw_open_cmd) n_open++;
    if (o_fw_close_cmd) n_close++;
    if (o_hk_req) n_hk++;
    if (o_s_axi_rvalid && i_s_axi_rready && rq.size() > 0) chk({o_s_axi_rresp, o_s_axi_rdata}, rq.pop_front());
    if (o_tx_valid && i_tx_ready) begin
      if (tq.size() == 0) chk(1'b1, 1'b0);
      else chk({o_tx_hk, o_tx_data}, tq.pop_front());
    end
  end
  initial begin
    #400000;
    err_total++;
    summarize();
  end
  initial begin
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = 5'h00;
    {i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_araddr} = '0;
    {i_pix_valid, i_pix_frame_end, i_fw_is_open, i_unit_test_busy, slow} = 5'h00;
    i_pix_ccd = 4'h0;
    i_pix_energy = 16'h0000;
    i_s_axi_wstrb = 4'hF;
    seed = 16'h4014;
    i_hk_word = lfsr(seed);
    i_rst = 1'b1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    chk(o_mode, CSM_M_IDLE);
    rd(8'h1C, {CSM_RESP_SLVERR, 32'h0000_0000});
    wr(8'h1C, 32'h0000_0001, CSM_RESP_SLVERR);
    wr(CSM_REG_TRIM, 32'h0000_0000, CSM_RESP_OKAY);
    wr(CSM_REG_DIAG_SP, 32'h0000_03CE, CSM_RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      wr(CSM_REG_PERIGEE, {31'h0000_0000, k == 1}, CSM_RESP_OKAY);
      i_unit_test_busy <= k == 3;
      wr(CSM_REG_CMD, cmds[k], CSM_RESP_OKAY);
      n0 = n_hk;
      chk(o_mode, mds[k]);
      if (k < 3) chk(o_setpoint, sps[k]);
      if (k == 1) chk({n_open[1:0], n_close[1:0]}, 4'h5);
      if (k == 3) chk({o_sim_source_en, o_pattern_inject_en}, 2'h3);
      wr(CSM_REG_CMD, 32'h0000_0003, CSM_RESP_OKAY);
      chk(o_mode, mds[k]);
      repeat (120) @(posedge i_clock);
      if (k == 2) chk(n_hk - n0 > 1, 1'b1);
      if (k == 3) chk(n_hk - n0, 0);
      wr(CSM_REG_CMD, 32'h0000_0001, CSM_RESP_OKAY);
      chk(o_mode, CSM_M_IDLE);
    end
    i_unit_test_busy <= 1'b0;
    wr(CSM_REG_CMD, 32'h0000_0007, CSM_RESP_OKAY);
    wr(CSM_REG_CMD, 32'h0000_0002, CSM_RESP_OKAY); // emergency exit
    chk(o_mode, CSM_M_SAFE);
    wr(CSM_REG_CMD, 32'h0000_0004, CSM_RESP_OKAY);
    chk(o_mode, CSM_M_SAFE);
    wr(CSM_REG_CMD, 32'h0000_0001, CSM_RESP_OKAY);
    diag(1'b1);
    while (o_mode !== CSM_M_IDLE) @(posedge i_clock);
    @(negedge i_clock);
    chk(tq.size(), 0);
    @(posedge i_clock);
    diag(1'b0);
    wr(CSM_REG_CMD, 32'h0000_0001, CSM_RESP_OKAY);
    tq.delete();
    chk({o_mode, o_tx_valid}, {CSM_M_IDLE, 1'b0});
    repeat (40) @(posedge i_clock);
    summarize();
  end
endmodule
`default_nettype wire
